// ---- eee_pkg.sv ----
// shared constants for the eee / time-sync mmd register bank
`default_nettype none
package eee_pkg;
	// ------------------------------------------------------------------
	// management (clause 22) access registers
	// ------------------------------------------------------------------
	localparam logic [4:0]  MGMT_REG_MMD_CTRL = 5'h0D; // access control
	localparam logic [4:0]  MGMT_REG_MMD_DATA = 5'h0E; // address or data
	localparam int          CTRL_FUNC_MSB     = 15;
	localparam int          CTRL_FUNC_LSB     = 14;
	localparam int          CTRL_DEVAD_MSB    = 4;
	localparam logic [1:0]  FUNC_ADDRESS      = 2'h0;
	localparam logic [1:0]  FUNC_DATA         = 2'h1;
	localparam logic [1:0]  FUNC_DATA_INC_RW  = 2'h2;
	localparam logic [1:0]  FUNC_DATA_INC_WR  = 2'h3;

	// ------------------------------------------------------------------
	// mmd device numbers and register numbers
	// ------------------------------------------------------------------
	localparam logic [4:0]  DEV_PMA = 5'h01;
	localparam logic [4:0]  DEV_PCS = 5'h03;
	localparam logic [4:0]  DEV_XS  = 5'h04;
	localparam logic [4:0]  DEV_AN  = 5'h07;
	localparam logic [15:0] REG_STATUS1     = 16'h0001;
	localparam logic [15:0] REG_EEE_CAP     = 16'h0014; // 20
	localparam logic [15:0] REG_WAKE_CNT    = 16'h0016; // 22
	localparam logic [15:0] REG_LOCAL_ADV   = 16'h003C; // 60
	localparam logic [15:0] REG_PARTNER_ADV = 16'h003D; // 61
	localparam logic [15:0] REG_TS_CAP      = 16'h0708; // 1800
	localparam logic [15:0] REG_TS_LAST     = 16'h0710; // 1808

	// ------------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------------
	localparam int          BIT_LINK       = 2;
	localparam int          BIT_TX_LPI_LH  = 11;
	localparam int          BIT_RX_LPI_LH  = 10;
	localparam int          BIT_TX_LPI_NOW = 9;
	localparam int          BIT_RX_LPI_NOW = 8;
	localparam int          BIT_EEE_1000T  = 2;
	localparam int          BIT_EEE_100TX  = 1;
	localparam int          BIT_TS_TX      = 1;
	localparam int          BIT_TS_RX      = 0;
	localparam logic        LL_RESET       = 1'b0;
	localparam logic        LH_RESET       = 1'b0;
	localparam logic [1:0]  ADV_RESET      = 2'h0;
	localparam logic [15:0] WAKE_RESET     = 16'h0000;
	localparam logic [15:0] WAKE_MAX       = 16'hFFFF;
	localparam logic [15:0] ZERO16         = 16'h0000;
endpackage : eee_pkg
`default_nettype wire

// ---- eee_mmd_regs.sv ----
// eee status and time-sync register bank behind mmd indirect access
`timescale 1ns/1ps
`default_nettype none
module eee_mmd_regs #(
	parameter logic [1:0] PMA_TS_CAP   = 2'h3,
	parameter logic [1:0] PCS_TS_CAP   = 2'h3,
	parameter logic [1:0] XS_TS_CAP    = 2'h3,
	parameter logic       EEE_CAP_1000 = 1'b1,
	parameter logic       EEE_CAP_100  = 1'b1
) (
	input  wire logic        CLK,
	input  wire logic        RSTN,
	input  wire logic        SOFT_RESET,
	input  wire logic [4:0]  MGMT_ADDR,
	input  wire logic [15:0] MGMT_WDATA,
	input  wire logic        MGMT_WR,
	input  wire logic        MGMT_RD,
	output logic      [15:0] MGMT_RDATA,
	output logic             MGMT_RVALID,
	input  wire logic        PMA_LINK_UP,
	input  wire logic        PCS_LINK_UP,
	input  wire logic        TX_LPI_ACTIVE,
	input  wire logic        RX_LPI_ACTIVE,
	input  wire logic        WAKE_FAULT,
	input  wire logic        AN_COMPLETE,
	input  wire logic        PARTNER_ADV_1000T,
	input  wire logic        PARTNER_ADV_100TX,
	input  wire logic [15:0] PMA_TX_DLY_MAX,
	input  wire logic [15:0] PMA_TX_DLY_MIN,
	input  wire logic [15:0] PMA_RX_DLY_MAX,
	input  wire logic [15:0] PMA_RX_DLY_MIN,
	input  wire logic [31:0] PCS_TX_DLY_MAX,
	input  wire logic [31:0] PCS_TX_DLY_MIN,
	input  wire logic [31:0] PCS_RX_DLY_MAX,
	input  wire logic [31:0] PCS_RX_DLY_MIN,
	input  wire logic [15:0] XS_TX_DLY_MAX,
	input  wire logic [15:0] XS_TX_DLY_MIN,
	input  wire logic [15:0] XS_RX_DLY_MAX,
	input  wire logic [15:0] XS_RX_DLY_MIN,
	output logic      [1:0]  LOCAL_EEE_ADV
);
	import eee_pkg::*;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic [1:0]  func_reg;
	logic [4:0]  devad_reg;
	logic [15:0] mmd_addr_reg;
	logic        pma_ll_reg;
	logic        pcs_ll_reg;
	logic        tx_lh_reg;
	logic        rx_lh_reg;
	logic [15:0] wake_cnt_reg;
	logic [1:0]  local_adv_reg;
	logic [1:0]  partner_adv_reg;
	logic [15:0] rdata_reg;
	logic        rvalid_reg;
	logic [15:0] rdata_next;
	logic [15:0] mmd_rdata;

	// ------------------------------------------------------------------
	// access decode
	// ------------------------------------------------------------------
	logic wr_ctrl;
	logic wr_data;
	logic rd_data;
	logic data_mode;
	logic mmd_rd;
	logic mmd_wr;
	logic rd_pma_stat;
	logic rd_pcs_stat;
	logic rd_wake;
	logic wr_local_adv;
	logic wr_partner_adv;
	logic addr_inc;
	logic link_up;
	logic ts_addr;
	logic srst;

	// a read beats a write offered in the same cycle
	assign wr_ctrl   = MGMT_WR && !MGMT_RD && MGMT_ADDR == MGMT_REG_MMD_CTRL;
	assign wr_data   = MGMT_WR && !MGMT_RD && MGMT_ADDR == MGMT_REG_MMD_DATA;
	assign rd_data   = MGMT_RD && MGMT_ADDR == MGMT_REG_MMD_DATA;
	assign data_mode = func_reg != FUNC_ADDRESS;
	assign mmd_rd    = rd_data && data_mode;
	assign mmd_wr    = wr_data && data_mode;
	assign srst      = !RSTN || SOFT_RESET;

	// register selection by device plus register number
	function automatic logic hit(input logic [4:0] dev,
		input logic [15:0] num);
		hit = devad_reg == dev && mmd_addr_reg == num;
	endfunction : hit

	assign rd_pma_stat    = mmd_rd && hit(DEV_PMA, REG_STATUS1);
	assign rd_pcs_stat    = mmd_rd && hit(DEV_PCS, REG_STATUS1);
	assign rd_wake        = mmd_rd && hit(DEV_PCS, REG_WAKE_CNT);
	assign wr_local_adv   = mmd_wr && hit(DEV_AN, REG_LOCAL_ADV);
	assign wr_partner_adv = mmd_wr && hit(DEV_AN, REG_PARTNER_ADV);
	// function 11 steps the address on writes only
	assign addr_inc = (mmd_rd && func_reg == FUNC_DATA_INC_RW) ||
		(mmd_wr && (func_reg == FUNC_DATA_INC_RW ||
		func_reg == FUNC_DATA_INC_WR));
	// both live link indications must be up for delays to be shown
	assign link_up = PMA_LINK_UP && PCS_LINK_UP;
	assign ts_addr = (devad_reg == DEV_PMA || devad_reg == DEV_PCS ||
		devad_reg == DEV_XS) && mmd_addr_reg >= REG_TS_CAP &&
		mmd_addr_reg <= REG_TS_LAST;

	// ------------------------------------------------------------------
	// mmd access control and address pointer
	// ------------------------------------------------------------------
	// control word: function and device number
	always_ff @(posedge CLK) begin
		if (srst) begin
			func_reg  <= FUNC_ADDRESS;
			devad_reg <= 5'h00;
		end else if (wr_ctrl) begin
			func_reg  <= MGMT_WDATA[CTRL_FUNC_MSB:CTRL_FUNC_LSB];
			devad_reg <= MGMT_WDATA[CTRL_DEVAD_MSB:0];
		end
	end

	// one shared pointer; software re-writes it after changing device
	always_ff @(posedge CLK) begin
		if (srst) begin
			mmd_addr_reg <= ZERO16;
		end else if (wr_data && !data_mode) begin
			mmd_addr_reg <= MGMT_WDATA;
		end else if (addr_inc) begin
			mmd_addr_reg <= mmd_addr_reg + 16'h0001;
		end
	end

	// ------------------------------------------------------------------
	// latched status flags
	// ------------------------------------------------------------------
	// a read reloads the live level, so a drop in the read cycle survives
	always_ff @(posedge CLK) begin
		if (srst) begin
			pma_ll_reg <= LL_RESET;
		end else if (rd_pma_stat) begin
			pma_ll_reg <= PMA_LINK_UP;
		end else begin
			pma_ll_reg <= pma_ll_reg && PMA_LINK_UP;
		end
	end

	// pcs link and lpi flags all reload their live levels on a read of pcs status
	always_ff @(posedge CLK) begin
		if (srst) begin
			pcs_ll_reg <= LL_RESET;
			tx_lh_reg  <= LH_RESET;
			rx_lh_reg  <= LH_RESET;
		end else if (rd_pcs_stat) begin
			pcs_ll_reg <= PCS_LINK_UP;
			tx_lh_reg  <= TX_LPI_ACTIVE;
			rx_lh_reg  <= RX_LPI_ACTIVE;
		end else begin
			pcs_ll_reg <= pcs_ll_reg && PCS_LINK_UP;
			tx_lh_reg  <= tx_lh_reg || TX_LPI_ACTIVE;
			rx_lh_reg  <= rx_lh_reg || RX_LPI_ACTIVE;
		end
	end

	// ------------------------------------------------------------------
	// wake fault counter
	// ------------------------------------------------------------------
	// saturates rather than wrapping so a flood is not mistaken for few
	always_ff @(posedge CLK) begin
		if (srst) begin
			wake_cnt_reg <= WAKE_RESET;
		end else if (rd_wake) begin
			wake_cnt_reg <= WAKE_FAULT ? 16'h0001 : WAKE_RESET;
		end else if (WAKE_FAULT && wake_cnt_reg != WAKE_MAX) begin
			wake_cnt_reg <= wake_cnt_reg + 16'h0001;
		end
	end

	// ------------------------------------------------------------------
	// advertisement registers
	// ------------------------------------------------------------------
	// local advert drives the next page engine directly
	always_ff @(posedge CLK) begin
		if (srst) begin
			local_adv_reg <= ADV_RESET;
		end else if (wr_local_adv) begin
			local_adv_reg <= {MGMT_WDATA[BIT_EEE_1000T],
				MGMT_WDATA[BIT_EEE_100TX]};
		end
	end

	// partner advert only moves on autoneg completion, never on writes
	always_ff @(posedge CLK) begin
		if (srst) begin
			partner_adv_reg <= ADV_RESET;
		end else if (AN_COMPLETE) begin
			partner_adv_reg <= {PARTNER_ADV_1000T, PARTNER_ADV_100TX};
		end
	end

	// ------------------------------------------------------------------
	// read multiplexer
	// ------------------------------------------------------------------
	// unmapped mmd locations read zero
	always_comb begin
		mmd_rdata = ZERO16;
		case ({devad_reg, mmd_addr_reg})
			{DEV_PMA, REG_STATUS1}: mmd_rdata[BIT_LINK] = pma_ll_reg;
			{DEV_PCS, REG_STATUS1}: begin
				mmd_rdata[BIT_LINK]       = pcs_ll_reg;
				mmd_rdata[BIT_TX_LPI_LH]  = tx_lh_reg;
				mmd_rdata[BIT_RX_LPI_LH]  = rx_lh_reg;
				mmd_rdata[BIT_TX_LPI_NOW] = TX_LPI_ACTIVE;
				mmd_rdata[BIT_RX_LPI_NOW] = RX_LPI_ACTIVE;
			end
			{DEV_PCS, REG_EEE_CAP}: begin
				mmd_rdata[BIT_EEE_1000T] = EEE_CAP_1000;
				mmd_rdata[BIT_EEE_100TX] = EEE_CAP_100;
			end
			{DEV_PCS, REG_WAKE_CNT}: mmd_rdata = wake_cnt_reg;
			{DEV_AN, REG_LOCAL_ADV}: begin
				mmd_rdata[BIT_EEE_1000T] = local_adv_reg[1];
				mmd_rdata[BIT_EEE_100TX] = local_adv_reg[0];
			end
			{DEV_AN, REG_PARTNER_ADV}: begin
				mmd_rdata[BIT_EEE_1000T] = partner_adv_reg[1];
				mmd_rdata[BIT_EEE_100TX] = partner_adv_reg[0];
			end
			{DEV_PMA, REG_TS_CAP}: begin
				mmd_rdata[BIT_TS_TX] = PMA_TS_CAP[1];
				mmd_rdata[BIT_TS_RX] = PMA_TS_CAP[0];
			end
			{DEV_PMA, 16'h0709}: mmd_rdata = PMA_TX_DLY_MAX;
			{DEV_PMA, 16'h070B}: mmd_rdata = PMA_TX_DLY_MIN;
			{DEV_PMA, 16'h070D}: mmd_rdata = PMA_RX_DLY_MAX;
			{DEV_PMA, 16'h070F}: mmd_rdata = PMA_RX_DLY_MIN;
			{DEV_PCS, REG_TS_CAP}: begin
				mmd_rdata[BIT_TS_TX] = PCS_TS_CAP[1];
				mmd_rdata[BIT_TS_RX] = PCS_TS_CAP[0];
			end
			{DEV_PCS, 16'h0709}: mmd_rdata = PCS_TX_DLY_MAX[15:0];
			{DEV_PCS, 16'h070A}: mmd_rdata = PCS_TX_DLY_MAX[31:16];
			{DEV_PCS, 16'h070B}: mmd_rdata = PCS_TX_DLY_MIN[15:0];
			{DEV_PCS, 16'h070C}: mmd_rdata = PCS_TX_DLY_MIN[31:16];
			{DEV_PCS, 16'h070D}: mmd_rdata = PCS_RX_DLY_MAX[15:0];
			{DEV_PCS, 16'h070E}: mmd_rdata = PCS_RX_DLY_MAX[31:16];
			{DEV_PCS, 16'h070F}: mmd_rdata = PCS_RX_DLY_MIN[15:0];
			{DEV_PCS, 16'h0710}: mmd_rdata = PCS_RX_DLY_MIN[31:16];
			{DEV_XS, REG_TS_CAP}: begin
				mmd_rdata[BIT_TS_TX] = XS_TS_CAP[1];
				mmd_rdata[BIT_TS_RX] = XS_TS_CAP[0];
			end
			{DEV_XS, 16'h0709}: mmd_rdata = XS_TX_DLY_MAX;
			{DEV_XS, 16'h070B}: mmd_rdata = XS_TX_DLY_MIN;
			{DEV_XS, 16'h070D}: mmd_rdata = XS_RX_DLY_MAX;
			{DEV_XS, 16'h070F}: mmd_rdata = XS_RX_DLY_MIN;
			default: mmd_rdata = ZERO16;
		endcase
		if (ts_addr && !link_up) begin
			mmd_rdata = ZERO16;
		end
	end

	// management-level answer: control word, pointer or mmd data
	always_comb begin
		rdata_next = ZERO16;
		if (MGMT_ADDR == MGMT_REG_MMD_CTRL) begin
			rdata_next[CTRL_FUNC_MSB:CTRL_FUNC_LSB] = func_reg;
			rdata_next[CTRL_DEVAD_MSB:0]            = devad_reg;
		end else if (MGMT_ADDR == MGMT_REG_MMD_DATA) begin
			rdata_next = data_mode ? mmd_rdata : mmd_addr_reg;
		end
	end

	// read data is captured one cycle after the strobe
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			rdata_reg  <= ZERO16;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= MGMT_RD;
			if (MGMT_RD) begin
				rdata_reg <= rdata_next;
			end
		end
	end

	assign MGMT_RDATA    = rdata_reg;
	assign MGMT_RVALID   = rvalid_reg;
	assign LOCAL_EEE_ADV = local_adv_reg;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	sequence s_pcs_read;
		rd_pcs_stat ##1 MGMT_RVALID;
	endsequence

	sequence s_adv_write;
		wr_local_adv && !SOFT_RESET;
	endsequence

	property p_pma_ll_drop;
		@(posedge CLK) disable iff (srst)
		!PMA_LINK_UP |=> !pma_ll_reg;
	endproperty
	a_pma_ll_drop: assert property (p_pma_ll_drop)
		else $error("pma link latch missed a drop");

	property p_pma_ll_hold;
		@(posedge CLK) disable iff (srst)
		!pma_ll_reg && !rd_pma_stat |=> !pma_ll_reg;
	endproperty
	a_pma_ll_hold: assert property (p_pma_ll_hold)
		else $error("pma link latch released without a read");

	property p_pcs_ll_read;
		@(posedge CLK) disable iff (srst)
		rd_pcs_stat && !pcs_ll_reg |-> s_pcs_read ##0 !MGMT_RDATA[BIT_LINK];
	endproperty
	a_pcs_ll_read: assert property (p_pcs_ll_read)
		else $error("pcs link latch not shown low on read");

	property p_tx_lh_set;
		@(posedge CLK) disable iff (srst)
		TX_LPI_ACTIVE |=> tx_lh_reg;
	endproperty
	a_tx_lh_set: assert property (p_tx_lh_set)
		else $error("tx lpi latch not set");

	property p_rx_lh_hold;
		@(posedge CLK) disable iff (srst)
		rx_lh_reg && !rd_pcs_stat |=> rx_lh_reg [*1] ##0 rx_lh_reg;
	endproperty
	a_rx_lh_hold: assert property (p_rx_lh_hold)
		else $error("rx lpi latch dropped without a read");

	property p_tx_now;
		@(posedge CLK) disable iff (srst)
		s_pcs_read |-> MGMT_RDATA[BIT_TX_LPI_NOW] == $past(TX_LPI_ACTIVE);
	endproperty
	a_tx_now: assert property (p_tx_now)
		else $error("tx lpi indication wrong");

	property p_rx_now;
		@(posedge CLK) disable iff (srst)
		s_pcs_read |-> MGMT_RDATA[BIT_RX_LPI_NOW] == $past(RX_LPI_ACTIVE);
	endproperty
	a_rx_now: assert property (p_rx_now)
		else $error("rx lpi indication wrong");

	property p_wake_inc;
		@(posedge CLK) disable iff (srst)
		WAKE_FAULT && !rd_wake && wake_cnt_reg != WAKE_MAX
		|=> wake_cnt_reg == $past(wake_cnt_reg) + 16'h0001;
	endproperty
	a_wake_inc: assert property (p_wake_inc)
		else $error("wake counter did not count a fault");

	property p_wake_clr;
		@(posedge CLK) disable iff (srst)
		rd_wake && !WAKE_FAULT |=> wake_cnt_reg == WAKE_RESET;
	endproperty
	a_wake_clr: assert property (p_wake_clr)
		else $error("wake counter not cleared by read");

	property p_adv_out;
		@(posedge CLK) disable iff (srst)
		s_adv_write |=> LOCAL_EEE_ADV ==
			{$past(MGMT_WDATA[BIT_EEE_1000T]), $past(MGMT_WDATA[BIT_EEE_100TX])};
	endproperty
	a_adv_out: assert property (p_adv_out)
		else $error("local advert not updated by write");

	property p_lp_ro;
		@(posedge CLK) disable iff (srst)
		wr_partner_adv && !AN_COMPLETE |=> $stable(partner_adv_reg);
	endproperty
	a_lp_ro: assert property (p_lp_ro)
		else $error("partner advert changed by a write");

	property p_lp_load;
		@(posedge CLK) disable iff (srst)
		AN_COMPLETE && !SOFT_RESET |=> partner_adv_reg ==
			$past({PARTNER_ADV_1000T, PARTNER_ADV_100TX});
	endproperty
	a_lp_load: assert property (p_lp_load)
		else $error("partner advert not loaded on autoneg complete");

	property p_ts_zero;
		@(posedge CLK) disable iff (srst)
		mmd_rd && ts_addr && !link_up |=> MGMT_RDATA == ZERO16;
	endproperty
	a_ts_zero: assert property (p_ts_zero)
		else $error("time-sync register nonzero while link down");
endmodule : eee_mmd_regs
`default_nettype wire

// ---- eee_mgmt_host.sv ----
// station management host model: mmd indirect access over clause-22 cycles
`timescale 1ns/1ps
`default_nettype none
module eee_mgmt_host (
	input  wire logic        CLK,
	output var  logic [4:0]  MGMT_ADDR,
	output var  logic [15:0] MGMT_WDATA,
	output var  logic        MGMT_WR,
	output var  logic        MGMT_RD,
	input  wire logic [15:0] MGMT_RDATA,
	input  wire logic        MGMT_RVALID
);
	import eee_pkg::*;

	// ------------------------------------------------------------
	// clause-22 cycles
	// ------------------------------------------------------------
	// idle bus from time zero
	initial begin
		MGMT_ADDR  = 5'h00;
		MGMT_WDATA = 16'h0000;
		MGMT_WR    = 1'b0;
		MGMT_RD    = 1'b0;
	end

	// one write strobe; data inverted after release so stale data is unusable
	task automatic c22_wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge CLK);
		MGMT_ADDR  <= a;
		MGMT_WDATA <= d;
		MGMT_WR    <= 1'b1;
		@(posedge CLK);
		MGMT_WR    <= 1'b0;
		MGMT_WDATA <= ~d;
	endtask : c22_wr

	// one read strobe, answer awaited for a bounded number of cycles
	task automatic c22_rd(input logic [4:0] a, output logic [15:0] d,
		output bit ok);
		ok = 1'b0;
		d  = 16'h0000;
		@(posedge CLK);
		MGMT_ADDR <= a;
		MGMT_RD   <= 1'b1;
		@(posedge CLK);
		MGMT_RD   <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(posedge CLK);
			if (!ok && MGMT_RVALID === 1'b1) begin
				d  = MGMT_RDATA;
				ok = 1'b1;
			end
		end
	endtask : c22_rd

	// ------------------------------------------------------------
	// mmd indirect access
	// ------------------------------------------------------------
	// device plus register number select the location
	task automatic mmd_sel(input logic [4:0] dev, input logic [15:0] num);
		c22_wr(MGMT_REG_MMD_CTRL, {FUNC_ADDRESS, 9'h000, dev});
		c22_wr(MGMT_REG_MMD_DATA, num);
		c22_wr(MGMT_REG_MMD_CTRL, {FUNC_DATA, 9'h000, dev});
	endtask : mmd_sel

	task automatic mmd_rd(input logic [4:0] dev, input logic [15:0] num,
		output logic [15:0] d, output bit ok);
		mmd_sel(dev, num);
		c22_rd(MGMT_REG_MMD_DATA, d, ok);
	endtask : mmd_rd

	task automatic mmd_wr(input logic [4:0] dev, input logic [15:0] num,
		input logic [15:0] d);
		mmd_sel(dev, num);
		c22_wr(MGMT_REG_MMD_DATA, d);
	endtask : mmd_wr
endmodule : eee_mgmt_host
`default_nettype wire

// ---- eee_timesync_mmd_status_regs_tb.sv ----
// self-checking bench for the eee / time-sync mmd register bank
`timescale 1ns/1ps
`default_nettype none
module eee_timesync_mmd_status_regs_tb;
	import eee_pkg::*;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        soft_rst = 1'b0;
	logic        pma_up = 1'b1;
	logic        pcs_up = 1'b1;
	logic        tx_lpi = 1'b0;
	logic        rx_lpi = 1'b0;
	logic        wake = 1'b0;
	logic        an_done = 1'b0;
	logic        lp_1000 = 1'b0;
	logic        lp_100 = 1'b0;
	logic [4:0]  m_addr;
	logic [15:0] m_wdata;
	logic        m_wr;
	logic        m_rd;
	logic [15:0] m_rdata;
	logic        m_rvalid;
	logic [1:0]  adv;
	logic [15:0] pma [4] = '{16'h1A01, 16'h1A03, 16'h1A05, 16'h1A07};
	logic [15:0] xs  [4] = '{16'h4C01, 16'h4C03, 16'h4C05, 16'h4C07};
	logic [31:0] pcs [4] = '{32'h3B02_3B01, 32'h3B04_3B03,
		32'h3B06_3B05, 32'h3B08_3B07};
	int          err_count = 0;
	int          num_checks = 0;

	// 200 MHz clock
	always #2.5 clk = ~clk;

	eee_mmd_regs eee_mmd_regs_inst (.CLK(clk), .RSTN(rstn),
		.SOFT_RESET(soft_rst), .MGMT_ADDR(m_addr), .MGMT_WDATA(m_wdata),
		.MGMT_WR(m_wr), .MGMT_RD(m_rd), .MGMT_RDATA(m_rdata),
		.MGMT_RVALID(m_rvalid), .PMA_LINK_UP(pma_up), .PCS_LINK_UP(pcs_up),
		.TX_LPI_ACTIVE(tx_lpi), .RX_LPI_ACTIVE(rx_lpi), .WAKE_FAULT(wake),
		.AN_COMPLETE(an_done), .PARTNER_ADV_1000T(lp_1000),
		.PARTNER_ADV_100TX(lp_100), .PMA_TX_DLY_MAX(pma[0]),
		.PMA_TX_DLY_MIN(pma[1]), .PMA_RX_DLY_MAX(pma[2]),
		.PMA_RX_DLY_MIN(pma[3]), .PCS_TX_DLY_MAX(pcs[0]),
		.PCS_TX_DLY_MIN(pcs[1]), .PCS_RX_DLY_MAX(pcs[2]),
		.PCS_RX_DLY_MIN(pcs[3]), .XS_TX_DLY_MAX(xs[0]),
		.XS_TX_DLY_MIN(xs[1]), .XS_RX_DLY_MAX(xs[2]),
		.XS_RX_DLY_MIN(xs[3]), .LOCAL_EEE_ADV(adv));

	eee_mgmt_host eee_mgmt_host_inst (.CLK(clk), .MGMT_ADDR(m_addr),
		.MGMT_WDATA(m_wdata), .MGMT_WR(m_wr), .MGMT_RD(m_rd),
		.MGMT_RDATA(m_rdata), .MGMT_RVALID(m_rvalid));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	// one management read judged; a lost answer ends the run at once
	task automatic rd22(input logic [4:0] a, input logic [15:0] exp);
		logic [15:0] d;
		bit          ok;
		eee_mgmt_host_inst.c22_rd(a, d, ok);
		if (!ok) begin
			err_count++;
			$display("MISMATCH t=%0t no answer got=%h exp=%h", $time, d, exp);
			close_out();
		end else begin
			chk(d, exp);
		end
	endtask : rd22

	task automatic rd(input logic [4:0] dev, input logic [15:0] num,
		input logic [15:0] exp);
		eee_mgmt_host_inst.mmd_sel(dev, num);
		rd22(MGMT_REG_MMD_DATA, exp);
	endtask : rd

	// expected time-sync word: k is the offset above the capability register
	function automatic logic [15:0] ts_exp(input logic [4:0] dev, input int k);
		logic [31:0] w;
		if (k == 0)
			return 16'h0003;
		w = pcs[(k - 1) / 2];
		if (dev == DEV_PCS)
			return (k % 2 == 1) ? w[15:0] : w[31:16];
		if (k % 2 == 0)
			return 16'h0000;
		return (dev == DEV_PMA) ? pma[(k - 1) / 2] : xs[(k - 1) / 2];
	endfunction : ts_exp

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic s_link();
		rd(DEV_PMA, REG_STATUS1, 16'h0000);
		rd(DEV_PMA, REG_STATUS1, 16'h0004);
		rd(DEV_PCS, REG_STATUS1, 16'h0000);
		rd(DEV_PCS, REG_STATUS1, 16'h0004);
		pma_up <= 1'b0;
		pcs_up <= 1'b0;
		cyc(3);
		pma_up <= 1'b1;
		pcs_up <= 1'b1;
		rd(DEV_PMA, REG_STATUS1, 16'h0000);
		rd(DEV_PCS, REG_STATUS1, 16'h0000);
		rd(DEV_PCS, REG_STATUS1, 16'h0004);
	endtask : s_link

	// tx lpi held across a read, then a short rx burst, then rx held
	task automatic s_lpi();
		tx_lpi <= 1'b1;
		rd(DEV_PCS, REG_STATUS1, 16'h0A04);
		tx_lpi <= 1'b0;
		rx_lpi <= 1'b1;
		cyc(2);
		rx_lpi <= 1'b0;
		rd(DEV_PCS, REG_STATUS1, 16'h0C04);
		rd(DEV_PCS, REG_STATUS1, 16'h0004);
		rx_lpi <= 1'b1;
		rd(DEV_PCS, REG_STATUS1, 16'h0504);
		rx_lpi <= 1'b0;
		rd(DEV_PCS, REG_STATUS1, 16'h0404);
		rd(DEV_PCS, REG_STATUS1, 16'h0004);
	endtask : s_lpi

	task automatic s_cap();
		rd(DEV_PCS, REG_EEE_CAP, 16'h0006);
		rd(DEV_PCS, 16'h0015, 16'h0000);
		rd22(5'h00, 16'h0000);
	endtask : s_cap

	// counter read clears it; a soft reset clears it too
	task automatic s_wake();
		wake <= 1'b1;
		cyc(3);
		wake <= 1'b0;
		rd(DEV_PCS, REG_WAKE_CNT, 16'h0003);
		rd(DEV_PCS, REG_WAKE_CNT, 16'h0000);
		wake <= 1'b1;
		cyc(2);
		wake <= 1'b0;
		soft_rst <= 1'b1;
		cyc(1);
		soft_rst <= 1'b0;
		rd(DEV_PCS, REG_WAKE_CNT, 16'h0000);
	endtask : s_wake

	task automatic s_adv();
		rd(DEV_AN, REG_LOCAL_ADV, 16'h0000);
		eee_mgmt_host_inst.mmd_wr(DEV_AN, REG_LOCAL_ADV, 16'hFFFF);
		rd(DEV_AN, REG_LOCAL_ADV, 16'h0006);
		chk({14'h0000, adv}, 16'h0003);
		lp_1000 <= 1'b1;
		an_done <= 1'b1;
		cyc(1);
		an_done <= 1'b0;
		rd(DEV_AN, REG_PARTNER_ADV, 16'h0004);
		eee_mgmt_host_inst.mmd_wr(DEV_AN, REG_PARTNER_ADV, 16'hFFFF);
		rd(DEV_AN, REG_PARTNER_ADV, 16'h0004);
		lp_1000 <= 1'b0;
		lp_100 <= 1'b1;
		an_done <= 1'b1;
		cyc(1);
		an_done <= 1'b0;
		rd(DEV_AN, REG_PARTNER_ADV, 16'h0002);
	endtask : s_adv

	// post-increment functions: rd+wr steps on reads, write-only does not
	task automatic s_inc();
		eee_mgmt_host_inst.mmd_sel(DEV_PCS, REG_TS_CAP + 16'h0001);
		eee_mgmt_host_inst.c22_wr(MGMT_REG_MMD_CTRL,
			{FUNC_DATA_INC_RW, 9'h000, DEV_PCS});
		for (int k = 1; k < 9; k++)
			rd22(MGMT_REG_MMD_DATA, ts_exp(DEV_PCS, k));
		eee_mgmt_host_inst.mmd_sel(DEV_AN, REG_LOCAL_ADV);
		eee_mgmt_host_inst.c22_wr(MGMT_REG_MMD_CTRL,
			{FUNC_DATA_INC_WR, 9'h000, DEV_AN});
		eee_mgmt_host_inst.c22_wr(MGMT_REG_MMD_DATA, 16'h0004);
		rd22(MGMT_REG_MMD_DATA, 16'h0002);
		rd22(MGMT_REG_MMD_DATA, 16'h0002);
		eee_mgmt_host_inst.c22_wr(MGMT_REG_MMD_CTRL,
			{FUNC_ADDRESS, 9'h000, DEV_AN});
		rd22(MGMT_REG_MMD_CTRL, {FUNC_ADDRESS, 9'h000, DEV_AN});
		rd22(MGMT_REG_MMD_DATA, REG_PARTNER_ADV);
		chk({14'h0000, adv}, 16'h0002);
	endtask : s_inc

	// every time-sync word with link up, then all zero with link down
	task automatic s_ts();
		logic [4:0] devs [3] = '{DEV_PMA, DEV_PCS, DEV_XS};
		for (int d = 0; d < 3; d++)
			for (int k = 0; k < 9; k++)
				rd(devs[d], REG_TS_CAP + 16'(k), ts_exp(devs[d], k));
		pma_up <= 1'b0;
		for (int d = 0; d < 3; d++)
			for (int k = 0; k < 9; k++)
				rd(devs[d], REG_TS_CAP + 16'(k), 16'h0000);
		pma_up <= 1'b1;
	endtask : s_ts

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		cyc(16);
		rstn <= 1'b1;
		s_link();
		s_lpi();
		s_cap();
		s_wake();
		s_adv();
		s_inc();
		s_ts();
		close_out();
	end
endmodule : eee_timesync_mmd_status_regs_tb
`default_nettype wire
